// file: bench/isp_prog.sv
// isp_prog: behavioural serial programmer facing the isp port pins
// driven by the bench tasks; pins change 1 ns after an i_clock edge
`timescale 1ns/1ns
`default_nettype none
module isp_prog #(
  parameter int unsigned SETTLE_CYC = 400000
) (
  // core clock and device output
  input  wire logic i_clock,
  input  wire logic i_miso,
  input  wire logic i_miso_oe,
  // programmer pins
  output var  logic o_sck,
  output var  logic o_mosi,
  output var  logic o_prog_reset_n
);
  logic last = 1'b0;
  // reset and sck low at power-up
  initial {o_sck, o_mosi, o_prog_reset_n} = 3'h0;
  task automatic start();
    // reset pulse with sck held low
    o_prog_reset_n = 1'b1;
    repeat (8) @(posedge i_clock);
    #1 o_prog_reset_n = 1'b0;
    repeat (SETTLE_CYC) @(posedge i_clock);
    #1;
  endtask
  task automatic stop();
    o_prog_reset_n = 1'b1;
  endtask
  task automatic xfer(input logic [31:0] w, output logic [31:0] r);
    for (int k = 31; k >= 0; k--) begin
      o_mosi = w[k];
      // four core clocks per sck phase
      repeat (4) @(posedge i_clock);
      #1 o_sck = 1'b1;
      // an undriven line reads as the inverse of its last bit
      r[k] = i_miso_oe ? i_miso : ~last;
      last = r[k];
      repeat (4) @(posedge i_clock);
      #1 o_sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// file: bench/serial_isp_programming_port_bench.sv
// serial_isp_programming_port_bench: random and corner tests of isp_port
// pins come from isp_prog; waits shortened through parameters
`timescale 1ns/1ns
`default_nettype none
module serial_isp_programming_port_bench;
  logic i_clock;
  logic i_reset_n;
  wire logic sck, mosi, prst_n, miso, miso_oe, en, busy, ovr;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [31:0] r;
  logic [11:0] wa;
  logic [8:0]  ea;
  logic [7:0]  d;
  logic [5:0]  lk;
  logic [7:0]  pg [64];
  isp_port #(.FLASH_WAIT_CYCLES(2000), .FUSE_WAIT_CYCLES(20),
    .EE_WAIT_CYCLES(2000), .ERASE_WAIT_CYCLES(20)) isp_port_i (
    .i_clock, .i_reset_n, .i_prog_reset_n(prst_n), .i_sck(sck),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
    .o_prog_enabled(en), .o_busy(busy), .o_overrun(ovr));
  isp_prog #(.SETTLE_CYC(100)) isp_prog_i (
    .i_clock, .i_miso(miso), .i_miso_oe(miso_oe), .o_sck(sck),
    .o_mosi(mosi), .o_prog_reset_n(prst_n));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  task automatic op(input logic [31:0] w);
    isp_prog_i.xfer(w, r);
  endtask
  task automatic idle();
    int k;
    for (k = 0; k < 16 && busy !== 1'b1; k++) #50;
    chk("busy", 8'h1, {7'h0, busy});
    for (k = 0; k < 20000 && busy !== 1'b0; k++) #50;
    if (busy !== 1'b0) begin
      $display("[FAIL] busy wait expected 0 seen %b", busy);
      n_mismatch++;
      complete_run();
    end
  endtask
  function automatic logic [7:0] lock_rd(input logic [5:0] l);
    return {2'h3, l};
  endfunction
  initial begin
    i_reset_n = 1'b0;
    void'($urandom(32'hDE85));
    repeat (10) @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    isp_prog_i.start();
    op(32'hAC80_0000);
    #800;
    chk("ignored", 8'h0, {7'h0, busy | en});
    // enable before any further program or erase
    op(32'hAC53_0000);
    chk("echo", 8'h53, r[15:8]);
    if (r[15:8] !== 8'h53) begin
      // no echo: pulse reset, send enable again
      isp_prog_i.start();
      op(32'hAC53_0000);
    end
    chk("enabled", 8'h1, {7'h0, en});
    op(32'hAC80_0000);
    idle();
    op(32'hA001_FF00);
    chk("erased ee", 8'hFF, r[7:0]);
    op(32'h280F_FF00);
    chk("erased flash", 8'hFF, r[7:0]);
    lk = 6'h3F;
    repeat (2) begin
      d = 8'($urandom);
      lk &= d[5:0];
      op({16'hACE0, 8'h00, 2'h3, d[5:0]});
      idle();
      op(32'h5800_0000);
      chk("lock", lock_rd(lk), r[7:0]);
    end
    for (int h = 0; h < 2; h++) begin
      d = 8'($urandom);
      op({8'hAC, h ? 8'hA8 : 8'hA0, 8'h00, d});
      idle();
      op(h ? 32'h5808_0000 : 32'h5000_0000);
      chk("fuse", d, r[7:0]);
    end
    for (int i = 0; i < 3; i++) begin
      ea = i ? 9'($urandom) : 9'h1FF;
      d = 8'($urandom);
      op({8'hC0, 7'h0, ea, d});
      // several polls; reads must not queue or overrun
      repeat (3) begin
        op({8'hA0, 7'h0, ea, 8'h00});
        chk("ee busy", 8'hFF, r[7:0]);
      end
      idle();
      op({8'hA0, 7'h0, ea, 8'h00});
      chk("ee", d, r[7:0]);
    end
    wa = {7'($urandom), 5'h00};
    for (int i = 0; i < 64; i++) begin
      pg[i] = 8'($urandom);
      // low byte then high byte per word
      op({4'h4, i[0], 3'h0, 8'h00, 3'h0, i[5:1], pg[i]});
    end
    op({8'h4C, 4'h0, wa[11:8], wa[7:5], 5'h00, 8'h00});
    op({4'h2, 1'b1, 7'h0, wa[11:8], wa[7:0] | 8'h1F, 8'h00});
    chk("page busy", 8'hFF, r[7:0]);
    idle();
    repeat (4) begin
      lk = 6'($urandom);
      op({4'h2, lk[0], 7'h0, wa[11:8], wa[7:5], lk[5:1], 8'h00});
      chk("flash", pg[lk], r[7:0]);
    end
    chk("overrun", 8'h0, {7'h0, ovr});
    isp_prog_i.stop();
    #400;
    chk("session end", 8'h0, {7'h0, en});
    complete_run();
  end
endmodule
`default_nettype wire

// file: rtl/isp_mem.sv
// isp_mem: simple two-port array, one write port and one read port
// read data come from a register one cycle after the address
// contents are not reset; they hold whatever was last written
`timescale 1ns/1ns
`default_nettype none
module isp_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned AW    = 9
) (
  // clock
  input  wire logic          i_clock,
  // write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  // read port
  input  wire logic [AW-1:0] i_raddr,
  output var  logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem_q [2**AW];

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end
endmodule
`default_nettype wire

// file: rtl/isp_pkg.sv
// isp_pkg: constants, types and helpers of the serial programming port
// assumes a 20 MHz core clock; wait times are turned into cycles here
package isp_pkg;
  localparam int unsigned CLK_MHZ = 20;
  // minimum wait delays in microseconds, then in core cycles
  localparam int unsigned FLASH_WAIT_US = 4500;
  localparam int unsigned FUSE_WAIT_US  = 4500;
  localparam int unsigned EE_WAIT_US    = 9000;
  localparam int unsigned ERASE_WAIT_US = 9000;
  localparam int unsigned FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_MHZ;
  localparam int unsigned FUSE_WAIT_CYC  = FUSE_WAIT_US * CLK_MHZ;
  localparam int unsigned EE_WAIT_CYC    = EE_WAIT_US * CLK_MHZ;
  localparam int unsigned ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
  localparam int unsigned WAIT_W = 18;
  localparam int unsigned CNT_W  = 14;
  // instruction bytes
  localparam logic [7:0] OP_PROG    = 8'hAC;
  localparam logic [7:0] ENABLE_KEY = 8'h53;
  localparam logic [7:0] OP_WR_PAGE = 8'h4C;
  localparam logic [7:0] OP_WR_EE   = 8'hC0;
  localparam logic [7:0] OP_RD_EE   = 8'hA0;
  localparam logic [7:0] OP_RD_FLO  = 8'h50;
  localparam logic [7:0] OP_RD_LKHI = 8'h58;
  localparam logic [7:0] OP_RD_SIG  = 8'h30;
  localparam logic [7:0] OP_RD_CAL  = 8'h38;
  localparam logic [7:0] SUB_FLO    = 8'hA0;
  localparam logic [7:0] SUB_FHI    = 8'hA8;
  localparam logic [7:0] SUB_RD_FHI = 8'h08;
  localparam logic [2:0] ERASE_SEL  = 3'h4;
  localparam logic [2:0] LOCK_SEL   = 3'h7;
  localparam logic [3:0] LOAD_NIB   = 4'h4;
  localparam logic [3:0] READ_NIB   = 4'h2;
  // array sizes
  localparam int unsigned FLASH_AW = 13;
  localparam int unsigned EE_AW    = 9;
  localparam int unsigned BUF_AW   = 6;
  localparam int unsigned PAGE_AW  = 7;
  localparam logic [13:0] PAGE_BYTES = 14'h0040;
  localparam logic [13:0] FLASH_LAST = 14'h1FFF;
  localparam logic [13:0] EE_BYTES   = 14'h0200;
  // reset and erased values
  localparam logic [7:0] ERASED      = 8'hFF;
  localparam logic [5:0] LOCK_RST    = 6'h3F;
  localparam logic [7:0] FUSE_LO_RST = 8'hFF;
  localparam logic [7:0] FUSE_HI_RST = 8'hFF;
  // identity and calibration bytes: values are arbitrary
  localparam logic [31:0] SIG_WORD = 32'h0012_3456;
  localparam logic [31:0] CAL_WORD = 32'h8080_8080;

  typedef logic [WAIT_W-1:0] isp_wait_t;
  typedef logic [CNT_W-1:0]  isp_cnt_t;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] data;
  } isp_instr_t;
  typedef enum logic [1:0] {
    EX_IDLE  = 2'h0,
    EX_COPY  = 2'h1,
    EX_WAIT  = 2'h3,
    EX_ERASE = 2'h2
  } isp_exec_t;
  typedef enum logic [1:0] {
    SRC_REG = 2'h0,
    SRC_FL  = 2'h1,
    SRC_EE  = 2'h2
  } isp_src_t;

  function automatic logic [8:0] ee_addr(input logic [7:0] b2,
                                         input logic [7:0] b3);
    ee_addr = {b2[0], b3};
  endfunction

  function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                           input logic [1:0]  s);
    pick_byte = w[{s, 3'h0} +: 8];
  endfunction
endpackage

// file: rtl/isp_port.sv
// isp_port: serial in-system programming port with its arrays
// pins arrive unsynchronised; sck half periods span at least 4 clocks
// Behaviour
// [RULE1] programmer keeps each sck phase over 2 or 3 core clocks
// [RULE2] mosi bits are taken at sck rising edges
// [RULE3] miso bits change at sck falling edges
// [RULE4] programmer holds reset and sck low at power-up, or pulses reset
// [RULE5] programmer waits 20 ms before the enable instruction
// [RULE6] enable is AC 53 xx xx, taken only while reset is low
// [RULE7] in sync, 0x53 echoes out during the third enable byte
// [RULE8] programmer sends all four bytes; no echo means reset pulse, retry
// [RULE9] load page writes one byte at 5-bit word address and high/low select
// [RULE10] programmer loads low byte before high byte per word
// [RULE11] write page 4C commits buffer to page given by 7 upper bits
// [RULE12] programmer sends only polling reads while a write runs
// [RULE13] programmer waits 4.5 ms or 9.0 ms without polling
// [RULE14] eeprom byte write erases the location before writing data
// [RULE15] reads within a flash page being written return 0xFF
// [RULE16] programmer uses full flash wait when writing 0xFF
// [RULE17] read of eeprom byte being written returns 0xFF until done
// [RULE18] programmer waits full eeprom wait when rewriting 0xFF
// [RULE19] chip erase AC 100x xxxx erases flash and eeprom
// [RULE20] flash read returns selected byte of word address in byte four
// [RULE21] eeprom read A0 returns stored byte of 9-bit address
// [RULE22] lock write ANDs six bits; zero means programmed
// [RULE23] fuse bytes written with A0/A8, read with 50/58
// [RULE24] programmer releases reset high to end the session
// [RULE25] programmer sends enable before any program or erase; the bench sends one chip erase before enable to check RULE28
// [RULE26] chip erase leaves every flash and eeprom byte at 0xFF
// [RULE27] bytes go msb first, four bytes back to back
// [RULE28] before enable, all other instructions are ignored
`timescale 1ns/1ns
`default_nettype none
module isp_port #(
  parameter int unsigned FLASH_WAIT_CYCLES = isp_pkg::FLASH_WAIT_CYC,
  parameter int unsigned FUSE_WAIT_CYCLES  = isp_pkg::FUSE_WAIT_CYC,
  parameter int unsigned EE_WAIT_CYCLES    = isp_pkg::EE_WAIT_CYC,
  parameter int unsigned ERASE_WAIT_CYCLES = isp_pkg::ERASE_WAIT_CYC
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_reset_n,
  // programming pins, asynchronous
  input  wire logic i_prog_reset_n,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  output var  logic o_miso,
  output var  logic o_miso_oe,
  // status
  output var  logic o_prog_enabled,
  output var  logic o_busy,
  output var  logic o_overrun
);
  localparam isp_pkg::isp_wait_t FL_W =
    isp_pkg::isp_wait_t'(FLASH_WAIT_CYCLES - 1);
  localparam isp_pkg::isp_wait_t FU_W =
    isp_pkg::isp_wait_t'(FUSE_WAIT_CYCLES - 1);
  localparam isp_pkg::isp_wait_t EE_W =
    isp_pkg::isp_wait_t'(EE_WAIT_CYCLES - 1);
  localparam isp_pkg::isp_wait_t ER_W =
    isp_pkg::isp_wait_t'(ERASE_WAIT_CYCLES - 1);

  // pin synchroniser: {reset pin, sck, mosi}
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       sck_prev_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q     <= 3'h4;
      sync_q     <= 3'h4;
      sck_prev_q <= 1'b0;
    end else begin
      meta_q     <= {i_prog_reset_n, i_sck, i_mosi};
      sync_q     <= meta_q;
      sck_prev_q <= sync_q[1];
    end
  end

  wire prog_low = !sync_q[2];
  wire mosi_s   = sync_q[0];
  wire sck_rise = prog_low && sync_q[1] && !sck_prev_q;
  wire sck_fall = prog_low && !sync_q[1] && sck_prev_q;

  // receiver and framing
  logic [2:0] bit_q;
  logic [1:0] idx_q;
  logic [7:0] rx_q;
  logic [7:0] b1_q;
  logic [7:0] b2_q;
  logic [7:0] b3_q;
  logic       en_q;
  logic       f_ready;

  // [RULE2] shift on rise
  wire [7:0] rx_next    = {rx_q[6:0], mosi_s};
  wire       byte_done  = sck_rise && (bit_q == 3'h7);
  wire       instr_done = byte_done && (idx_q == 2'h3);
  wire       is_enable  = (b1_q == isp_pkg::OP_PROG) &&
                          (b2_q == isp_pkg::ENABLE_KEY);
  // reads answer on the link and never queue, so polling cannot overrun
  wire       is_write   = (b1_q == isp_pkg::OP_PROG) ||
                          (b1_q[7:4] == isp_pkg::LOAD_NIB) ||
                          (b1_q == isp_pkg::OP_WR_EE);
  // [RULE28] gate until enabled
  wire       instr_wr   = instr_done && en_q && !is_enable && is_write;
  wire       push       = instr_wr && f_ready;

  wire isp_pkg::isp_instr_t instr = '{op: b1_q, b2: b2_q, b3: b3_q,
                                      data: rx_next};

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_q <= 3'h0;
      idx_q <= 2'h0;
      rx_q  <= 8'h00;
      b1_q  <= 8'h00;
      b2_q  <= 8'h00;
      b3_q  <= 8'h00;
      en_q  <= 1'b0;
    end else if (!prog_low) begin
      // reset pin high drops framing and the session
      bit_q <= 3'h0;
      idx_q <= 2'h0;
      en_q  <= 1'b0;
    end else if (sck_rise) begin
      rx_q  <= rx_next;
      // [RULE27] msb first, gapless bytes
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        idx_q <= idx_q + 2'h1;
      end
      if (byte_done && idx_q == 2'h0) begin
        b1_q <= rx_next;
      end
      if (byte_done && idx_q == 2'h1) begin
        b2_q <= rx_next;
      end
      if (byte_done && idx_q == 2'h2) begin
        b3_q <= rx_next;
      end
      // [RULE6] enable while low
      if (instr_done && is_enable) begin
        en_q <= 1'b1;
      end
    end
  end

  // read lookup at the end of byte three
  logic [5:0]  lock_q;
  logic [7:0]  fuse_lo_q;
  logic [7:0]  fuse_hi_q;
  logic        busy_fl_q;
  logic        busy_ee_q;
  logic        busy_er_q;
  logic [6:0]  page_q;
  logic [8:0]  ee_addr_q;
  logic [7:0]  fl_rdata;
  logic [7:0]  ee_rdata;

  wire rd_on   = en_q && byte_done && (idx_q == 2'h2);
  // [RULE20] word address and byte select
  wire [12:0] fl_raddr = {b2_q[3:0], rx_next, b1_q[3]};
  // [RULE21] 9-bit eeprom address
  wire [8:0]  ee_raddr = isp_pkg::ee_addr(b2_q, rx_next);
  wire rd_fl   = rd_on && (b1_q[7:4] == isp_pkg::READ_NIB) &&
                 (b1_q[2:0] == 3'h0);
  wire rd_ee   = rd_on && (b1_q == isp_pkg::OP_RD_EE);
  // [RULE15] busy page reads erased
  wire fl_hit  = (busy_fl_q && (fl_raddr[12:6] == page_q)) || busy_er_q;
  // [RULE17] busy byte reads erased
  wire ee_hit  = (busy_ee_q && (ee_raddr == ee_addr_q)) || busy_er_q;
  wire hi_sel  = (b2_q == isp_pkg::SUB_RD_FHI);
  // [RULE23] fuse and lock readback
  wire [7:0] lk_val  = hi_sel ? fuse_hi_q : {2'b11, lock_q};
  wire [7:0] reg_val =
    !rd_on                        ? rx_next :
    b1_q == isp_pkg::OP_RD_FLO    ? fuse_lo_q :
    b1_q == isp_pkg::OP_RD_LKHI   ? lk_val :
    b1_q == isp_pkg::OP_RD_SIG    ?
      isp_pkg::pick_byte(isp_pkg::SIG_WORD, rx_next[1:0]) :
    b1_q == isp_pkg::OP_RD_CAL    ?
      isp_pkg::pick_byte(isp_pkg::CAL_WORD, rx_next[1:0]) : rx_next;
  wire isp_pkg::isp_src_t src_d = rd_fl ? isp_pkg::SRC_FL :
                                  rd_ee ? isp_pkg::SRC_EE :
                                  isp_pkg::SRC_REG;
  wire hit_d = (rd_fl && fl_hit) || (rd_ee && ee_hit);

  // answer byte: echo of the byte just taken, or read data
  logic              pend_q;
  logic              hit_q;
  isp_pkg::isp_src_t src_q;
  logic [7:0]        regv_q;
  logic [7:0]        resp_q;
  logic [7:0]        tx_q;

  wire [7:0] rd_val = hit_q ? isp_pkg::ERASED :
                      src_q == isp_pkg::SRC_FL ? fl_rdata :
                      src_q == isp_pkg::SRC_EE ? ee_rdata : regv_q;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_q <= 1'b0;
      hit_q  <= 1'b0;
      src_q  <= isp_pkg::SRC_REG;
      regv_q <= 8'h00;
      resp_q <= 8'h00;
    end else begin
      pend_q <= byte_done;
      if (byte_done) begin
        hit_q  <= hit_d;
        src_q  <= src_d;
        regv_q <= reg_val;
      end
      // [RULE7] echo second byte
      if (pend_q) begin
        resp_q <= rd_val;
      end
    end
  end

  // transmitter; ready two clocks after the last rise of a byte
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_q      <= 8'h00;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= prog_low;
      // [RULE3] change on fall
      if (sck_fall && bit_q == 3'h0) begin
        o_miso <= resp_q[7];
        tx_q   <= {resp_q[6:0], 1'b0};
      end else if (sck_fall) begin
        o_miso <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // two-entry instruction buffer between framer and executor
  isp_pkg::isp_instr_t ent_q [2];
  logic                wp_q;
  logic                rp_q;
  logic [1:0]          fcnt_q;
  logic                ovr_q;
  isp_pkg::isp_exec_t  st_q;
  isp_pkg::isp_exec_t  st_d;

  assign f_ready = (fcnt_q != 2'h2);
  wire f_valid = (fcnt_q != 2'h0);
  wire isp_pkg::isp_instr_t h = ent_q[rp_q];
  // executor stalls the buffer while it walks or waits
  wire take = f_valid && (st_q == isp_pkg::EX_IDLE);

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ent_q[0] <= '0;
      ent_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      fcnt_q   <= 2'h0;
      ovr_q    <= 1'b0;
    end else begin
      if (push) begin
        ent_q[wp_q] <= instr;
        wp_q        <= !wp_q;
      end
      if (take) begin
        rp_q <= !rp_q;
      end
      if (push && !take) begin
        fcnt_q <= fcnt_q + 2'h1;
      end else if (take && !push) begin
        fcnt_q <= fcnt_q - 2'h1;
      end
      if (instr_wr && !f_ready) begin
        ovr_q <= 1'b1;
      end else if (!prog_low) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // executor decode
  wire h_prog  = (h.op == isp_pkg::OP_PROG);
  wire x_erase = take && h_prog && (h.b2[7:5] == isp_pkg::ERASE_SEL);
  wire x_lock  = take && h_prog && (h.b2[7:5] == isp_pkg::LOCK_SEL);
  wire x_flo   = take && h_prog && (h.b2 == isp_pkg::SUB_FLO);
  wire x_fhi   = take && h_prog && (h.b2 == isp_pkg::SUB_FHI);
  wire x_load  = take && (h.op[7:4] == isp_pkg::LOAD_NIB) &&
                 (h.op[2:0] == 3'h0);
  wire x_page  = take && (h.op == isp_pkg::OP_WR_PAGE);
  wire x_ee    = take && (h.op == isp_pkg::OP_WR_EE);
  wire x_fuse  = x_lock || x_flo || x_fhi;
  wire [6:0] page_sel = {h.b2[3:0], h.b3[7:5]};
  wire [5:0] lock_new = lock_q & h.data[5:0];

  isp_pkg::isp_cnt_t  cnt_q;
  isp_pkg::isp_wait_t wait_q;
  logic [7:0]         ee_data_q;
  logic               busy_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      isp_pkg::EX_IDLE: begin
        if (x_page) begin
          st_d = isp_pkg::EX_COPY;
        end else if (x_erase) begin
          st_d = isp_pkg::EX_ERASE;
        end else if (x_ee || x_fuse) begin
          st_d = isp_pkg::EX_WAIT;
        end
      end
      isp_pkg::EX_COPY: begin
        if (cnt_q == isp_pkg::PAGE_BYTES) begin
          st_d = isp_pkg::EX_WAIT;
        end
      end
      isp_pkg::EX_ERASE: begin
        if (cnt_q == isp_pkg::FLASH_LAST) begin
          st_d = isp_pkg::EX_WAIT;
        end
      end
      isp_pkg::EX_WAIT: begin
        if (wait_q == '0) begin
          st_d = isp_pkg::EX_IDLE;
        end
      end
      default: st_d = isp_pkg::EX_IDLE;
    endcase
  end

  wire in_copy  = (st_q == isp_pkg::EX_COPY);
  wire in_erase = (st_q == isp_pkg::EX_ERASE);
  wire to_wait  = (st_q != isp_pkg::EX_WAIT) && (st_d == isp_pkg::EX_WAIT);
  wire wait_end = (st_q == isp_pkg::EX_WAIT) && (st_d == isp_pkg::EX_IDLE);
  // [RULE13] self-timed wait lengths
  wire isp_pkg::isp_wait_t wait_init = x_ee ? EE_W : x_fuse ? FU_W :
                                       in_erase ? ER_W : FL_W;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q      <= isp_pkg::EX_IDLE;
      busy_q    <= 1'b0;
      cnt_q     <= '0;
      wait_q    <= '0;
      busy_fl_q <= 1'b0;
      busy_ee_q <= 1'b0;
      busy_er_q <= 1'b0;
      page_q    <= 7'h00;
      ee_addr_q <= 9'h000;
      ee_data_q <= 8'h00;
    end else begin
      st_q   <= st_d;
      busy_q <= (st_d != isp_pkg::EX_IDLE);
      if (take) begin
        cnt_q <= '0;
      end else if (in_copy || in_erase) begin
        cnt_q <= cnt_q + 14'h0001;
      end
      if (to_wait) begin
        wait_q <= wait_init;
      end else if (st_q == isp_pkg::EX_WAIT && wait_q != '0) begin
        wait_q <= wait_q - 18'h00001;
      end
      // [RULE11] latch page to commit
      if (x_page) begin
        busy_fl_q <= 1'b1;
        page_q    <= page_sel;
      end
      if (x_erase) begin
        busy_er_q <= 1'b1;
      end
      if (x_ee) begin
        busy_ee_q <= 1'b1;
        ee_addr_q <= isp_pkg::ee_addr(h.b2, h.b3);
        ee_data_q <= h.data;
      end
      if (wait_end) begin
        busy_fl_q <= 1'b0;
        busy_ee_q <= 1'b0;
        busy_er_q <= 1'b0;
      end
    end
  end

  // lock and fuse bytes
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_q    <= isp_pkg::LOCK_RST;
      fuse_lo_q <= isp_pkg::FUSE_LO_RST;
      fuse_hi_q <= isp_pkg::FUSE_HI_RST;
    end else begin
      // [RULE22] zero programs a lock bit
      if (x_erase) begin
        lock_q <= isp_pkg::LOCK_RST;
      end else if (x_lock) begin
        lock_q <= lock_new;
      end
      // [RULE23] fuse bytes written whole
      if (x_flo) begin
        fuse_lo_q <= h.data;
      end
      if (x_fhi) begin
        fuse_hi_q <= h.data;
      end
    end
  end

  // array write ports; flash and eeprom read ports belong to the link, the page buffer is read by the executor
  wire [13:0] cnt_m1  = cnt_q - 14'h0001;
  // [RULE19] erase walks both arrays
  wire        fl_we   = (in_copy && cnt_q != '0) || in_erase;
  wire [12:0] fl_wadr = in_erase ? cnt_q[12:0] : {page_q, cnt_m1[5:0]};
  wire [7:0]  buf_rd;
  // [RULE26] erased value everywhere
  wire [7:0]  fl_wdat = in_erase ? isp_pkg::ERASED : buf_rd;
  wire        ee_done = wait_end && busy_ee_q;
  // [RULE14] erase byte, then write data
  wire        ee_we   = (in_erase && cnt_q < isp_pkg::EE_BYTES) ||
                        x_ee || ee_done;
  wire [8:0]  ee_wadr = in_erase ? cnt_q[8:0] :
                        x_ee ? isp_pkg::ee_addr(h.b2, h.b3) : ee_addr_q;
  wire [7:0]  ee_wdat = ee_done ? ee_data_q : isp_pkg::ERASED;
  // [RULE9] byte into page buffer
  wire [5:0]  buf_wad = {h.b3[4:0], h.op[3]};

  isp_mem #(.WIDTH(8), .AW(isp_pkg::FLASH_AW)) u_flash (
    .i_clock (i_clock),
    .i_we    (fl_we),
    .i_waddr (fl_wadr),
    .i_wdata (fl_wdat),
    .i_raddr (fl_raddr),
    .o_rdata (fl_rdata)
  );

  isp_mem #(.WIDTH(8), .AW(isp_pkg::EE_AW)) u_eeprom (
    .i_clock (i_clock),
    .i_we    (ee_we),
    .i_waddr (ee_wadr),
    .i_wdata (ee_wdat),
    .i_raddr (ee_raddr),
    .o_rdata (ee_rdata)
  );

  isp_mem #(.WIDTH(8), .AW(isp_pkg::BUF_AW)) u_page (
    .i_clock (i_clock),
    .i_we    (x_load),
    .i_waddr (buf_wad),
    .i_wdata (h.data),
    .i_raddr (cnt_q[5:0]),
    .o_rdata (buf_rd)
  );

  assign o_prog_enabled = en_q;
  assign o_busy         = busy_q;
  assign o_overrun      = ovr_q;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  property p_rx_sample;
    sck_rise |=> rx_q[0] == $past(mosi_s);
  endproperty
  a_rx_sample: assert property (p_rx_sample) // [RULE2]
    else $error("mosi bit not taken on sck rise");

  property p_miso_fall;
    $changed(o_miso) |-> $past(sck_fall);
  endproperty
  a_miso_fall: assert property (p_miso_fall) // [RULE3]
    else $error("miso changed away from sck fall");

  property p_echo;
    (byte_done && idx_q == 2'h1 && b1_q == isp_pkg::OP_PROG &&
     rx_next == isp_pkg::ENABLE_KEY) |=> ##1
      resp_q == isp_pkg::ENABLE_KEY;
  endproperty
  a_echo: assert property (p_echo) // [RULE7]
    else $error("enable key not echoed");

  property p_enable_low;
    $rose(en_q) |-> $past(instr_done && is_enable && prog_low);
  endproperty
  a_enable_low: assert property (p_enable_low) // [RULE6]
    else $error("enabled without a valid instruction");

  property p_gate;
    (!en_q && fcnt_q == 2'h0) |=> fcnt_q == 2'h0;
  endproperty
  a_gate: assert property (p_gate) // [RULE28]
    else $error("instruction queued before enable");

  property p_flash_ff;
    (rd_fl && fl_hit) |=> ##1 resp_q == isp_pkg::ERASED;
  endproperty
  a_flash_ff: assert property (p_flash_ff) // [RULE15]
    else $error("busy flash page did not read erased");

  property p_ee_ff;
    (rd_ee && ee_hit) |=> ##1 resp_q == isp_pkg::ERASED;
  endproperty
  a_ee_ff: assert property (p_ee_ff) // [RULE17]
    else $error("busy eeprom byte did not read erased");

  property p_autoerase;
    x_ee |-> (ee_we && ee_wdat == isp_pkg::ERASED) ##1
      (st_q == isp_pkg::EX_WAIT && busy_ee_q);
  endproperty
  a_autoerase: assert property (p_autoerase) // [RULE14]
    else $error("eeprom byte not erased before write");

  property p_page;
    x_page |=> st_q == isp_pkg::EX_COPY && page_q == $past(page_sel);
  endproperty
  a_page: assert property (p_page) // [RULE11]
    else $error("page write did not start copy");

  property p_lock;
    x_lock |=> lock_q == $past(lock_new);
  endproperty
  a_lock: assert property (p_lock) // [RULE22]
    else $error("lock bits not programmed by zeros");

  property p_frame;
    instr_done |=> idx_q == 2'h0 && bit_q == 3'h0;
  endproperty
  a_frame: assert property (p_frame) // [RULE27]
    else $error("framing lost after four bytes");
endmodule
`default_nettype wire
